// *** src/pcrc_top.sv ***
// Programmable CRC generator: register port, input FIFO, serial shifter
`timescale 1ns/1ps
`include "pcrc_cfg.svh"
module pcrc_top
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             crc_event
);
  pcrc_pkg::pcrc_req_type  req;
  pcrc_pkg::pcrc_poly_type poly;
  logic        idle_stop_select;
  logic        shift_go;
  logic [3:0]  poly_len_minus_one;
  logic [15:1] poly_tap_enables;
  logic [4:0]  fifo_word_count;
  logic        fifo_full_flag;
  logic        fifo_empty_flag;
  logic        sleep_req;
  logic        idle_req;
  logic [15:0] fifo_mem [16];
  logic [3:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [3:0]  bit_idx;
  logic [15:0] crc;
  logic        frozen;
  logic        shifting;
  logic        word_done;
  logic        push;
  logic        crc_load;
  logic [4:0]  depth;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // Both pointers wrap at the active depth; they stay in step only if the
  // length is changed while the FIFO is empty
  function automatic logic [3:0] ptr_next(input logic [3:0] p, input logic [4:0] d);
    ptr_next = (p + 4'h1) & ((d == `PCRC_DEPTH_LARGE) ? 4'h7 : 4'hF);
  endfunction

  function automatic logic [15:0] width_mask(input logic [3:0] len_m1);
    width_mask = 16'hFFFF >> (4'hF - len_m1);
  endfunction

  assign req.addr  = addr;
  assign req.wdata = wdata;
  assign req.wr    = wr;
  assign req.rd    = rd;
  assign poly.taps   = {poly_tap_enables, 1'b0};
  assign poly.len_m1 = poly_len_minus_one;

  // Only the power register stays writable while frozen, so software can wake it
  // clock gating stand-in
  assign frozen = sleep_req | (idle_req & idle_stop_select);
  assign depth = (poly_len_minus_one > `PCRC_LEN_SPLIT) ? `PCRC_DEPTH_LARGE
               : `PCRC_DEPTH_SMALL;
  assign shifting  = !frozen && shift_go && (fifo_word_count != 5'h00);
  assign word_done = shifting && (bit_idx == 4'h0);
  // one write is one full word
  assign push     = !frozen && req.wr && hit(req.addr, `PCRC_OFS_WDATA);
  assign crc_load = !frozen && req.wr && hit(req.addr, `PCRC_OFS_DATA);

  // Power-state inputs are software-visible here, so sleep and idle are testable
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sleep_req <= 1'b0;
      idle_req  <= 1'b0;
    end
    else if (req.wr && hit(req.addr, `PCRC_OFS_PWR))
    begin
      sleep_req <= req.wdata[`PCRC_BIT_SLEEP];
      idle_req  <= req.wdata[`PCRC_BIT_IDLE];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      idle_stop_select   <= 1'b0;
      shift_go           <= 1'b0;
      poly_len_minus_one <= 4'h0;
      poly_tap_enables   <= 15'h0000;
    end
    else if (!frozen && req.wr)
    begin
      if (hit(req.addr, `PCRC_OFS_CTRL))
      begin
        idle_stop_select   <= req.wdata[`PCRC_BIT_IDLE_STOP];
        shift_go           <= req.wdata[`PCRC_BIT_GO];
        poly_len_minus_one <= req.wdata[`PCRC_POS_LEN +: 4];
      end
      else if (hit(req.addr, `PCRC_OFS_TAPS))
      begin
        poly_tap_enables <= req.wdata[15:1];
      end
    end
  end

  // FIFO storage; words are masked to the active width on the way in
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      fifo_mem[wr_ptr] <= req.wdata & width_mask(poly_len_minus_one);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ptr          <= 4'h0;
      rd_ptr          <= 4'h0;
      fifo_word_count <= 5'h00;
    end
    else if (push && fifo_full_flag)
    begin
      // overflow wraps to empty
      // Queued words are dropped; the shifter sees an empty FIFO next cycle
      wr_ptr          <= rd_ptr;
      fifo_word_count <= 5'h00;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ptr_next(wr_ptr, depth);
      end
      if (word_done)
      begin
        rd_ptr <= ptr_next(rd_ptr, depth);
      end
      if (push && !word_done)
      begin
        fifo_word_count <= fifo_word_count + 5'h01;
      end
      else if (word_done && !push)
      begin
        fifo_word_count <= fifo_word_count - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fifo_full_flag  <= 1'b0;
      fifo_empty_flag <= 1'b1;
    end
    else if (push && fifo_full_flag)
    begin
      fifo_full_flag  <= 1'b0;
      fifo_empty_flag <= 1'b1;
    end
    // Full follows a length change one cycle late; the count itself is exact
    else if (!frozen)
    begin
      if (push && !word_done)
      begin
        fifo_full_flag  <= (fifo_word_count + 5'h01) == depth;
        fifo_empty_flag <= 1'b0;
      end
      else if (word_done && !push)
      begin
        fifo_full_flag  <= 1'b0;
        fifo_empty_flag <= fifo_word_count == 5'h01;
      end
      else
      begin
        fifo_full_flag  <= fifo_word_count == depth;
        fifo_empty_flag <= fifo_word_count == 5'h00;
      end
    end
  end

  // bit index walks MSB to LSB
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bit_idx <= 4'h0;
    end
    else if (frozen)
    begin
      bit_idx <= bit_idx;
    end
    else if (!shifting)
    begin
      bit_idx <= poly_len_minus_one;
    end
    else
    begin
      bit_idx <= (bit_idx == 4'h0) ? poly_len_minus_one : bit_idx - 4'h1;
    end
  end

  // A preload through the data register wins over a shift in the same cycle
  pcrc_lfsr u_lfsr
  (
    .mclk     (mclk),
    .srst     (srst),
    .run      (shifting),
    .bit_in   (fifo_mem[rd_ptr][bit_idx]),
    .load     (crc_load),
    .load_val (req.wdata),
    .poly     (poly),
    .crc      (crc)
  );

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      crc_event <= 1'b0;
    end
    else
    begin
      crc_event <= word_done && !push && (fifo_word_count == 5'h01);
    end
  end

  // Read data is zero outside its cycle, so stale data never looks valid
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rdata <= 16'h0000;
    end
    else if (req.rd)
    begin
      if (hit(req.addr, `PCRC_OFS_CTRL))
      begin
        rdata <= {2'b00, idle_stop_select, fifo_word_count, fifo_full_flag,
                  fifo_empty_flag, 1'b0, shift_go, poly_len_minus_one};
      end
      else if (hit(req.addr, `PCRC_OFS_TAPS))
      begin
        rdata <= {poly_tap_enables, 1'b0};
      end
      else if (hit(req.addr, `PCRC_OFS_DATA) || hit(req.addr, `PCRC_OFS_WDATA))
      begin
        rdata <= crc;
      end
      else if (hit(req.addr, `PCRC_OFS_PWR))
      begin
        rdata <= {14'h0000, idle_req, sleep_req};
      end
      else
      begin
        rdata <= 16'h0000;
      end
    end
    else
    begin
      rdata <= 16'h0000;
    end
  end
endmodule

// *** src/pcrc_cfg.svh ***
// Register offsets, field positions, reset values and sizes of the CRC generator
`ifndef PCRC_CFG_SVH
`define PCRC_CFG_SVH
`define PCRC_OFS_CTRL      4'h0
`define PCRC_OFS_TAPS      4'h2
`define PCRC_OFS_DATA      4'h4
`define PCRC_OFS_WDATA     4'h6
`define PCRC_OFS_PWR       4'h8
`define PCRC_BIT_IDLE_STOP 13
`define PCRC_POS_COUNT     8
`define PCRC_BIT_FULL      7
`define PCRC_BIT_EMPTY     6
`define PCRC_BIT_GO        4
`define PCRC_POS_LEN       0
`define PCRC_BIT_SLEEP     0
`define PCRC_BIT_IDLE      1
`define PCRC_DEPTH_SMALL   5'h10
`define PCRC_DEPTH_LARGE   5'h08
`define PCRC_LEN_SPLIT     4'h7
`define PCRC_RST_CTRL      16'h0040
`define PCRC_RST_TAPS      16'h0000
`endif

// *** src/pcrc_pkg.sv ***
// Types shared by the CRC generator files
package pcrc_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pcrc_req_type;

  typedef struct packed {
    logic [15:0] taps;
    logic [3:0]  len_m1;
  } pcrc_poly_type;
endpackage

// *** src/pcrc_lfsr.sv ***
// Serial CRC feedback register with programmable taps and length
`timescale 1ns/1ps
module pcrc_lfsr
(
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic                   run,
  input  wire logic                   bit_in,
  input  wire logic                   load,
  input  wire logic [15:0]            load_val,
  input  wire pcrc_pkg::pcrc_poly_type poly,
  output logic      [15:0]            crc
);
  logic [15:0] next_crc;
  logic        fb;

  always_comb
  begin
    fb = bit_in ^ crc[poly.len_m1];
    next_crc = 16'h0000;
    for (int i = 15; i >= 1; i--)
    begin
      next_crc[i] = crc[i - 1] ^ (fb & poly.taps[i]);
    end
    next_crc[0] = fb;
    for (int i = 0; i < 16; i++)
    begin
      if (i > int'(poly.len_m1))
      begin
        next_crc[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      crc <= 16'h0000;
    end
    else if (load)
    begin
      crc <= load_val;
    end
    else if (run)
    begin
      crc <= next_crc;
    end
  end
endmodule

// *** tb/pcrc_chk_sva.sv ***
// Port assertions for the CRC generator, bound to its top
`timescale 1ns/1ps
module pcrc_chk_sva
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        crc_event
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic ctl;
  assign ctl = rd && addr == 4'h0;
  a_ctrl_reset_value: assert property (ctl && $past(srst) |=> rdata == 16'h0040)
    else $error("control reset value wrong");
  a_ctrl_unused_zero: assert property (ctl |=> rdata[15:14] == 2'b00 && !rdata[5])
    else $error("control unused bits set");
  a_empty_at_zero: assert property (ctl |=> rdata[6] == (rdata[12:8] == 5'h00))
    else $error("empty flag wrong");
  a_full_at_depth: assert property (ctl |=>
    rdata[7] == (rdata[12:8] == (rdata[3] ? 5'h08 : 5'h10)))
    else $error("full flag wrong");
  a_count_in_depth: assert property (ctl |=> rdata[12:8] <= (rdata[3] ? 5'h08 : 5'h10))
    else $error("word count above depth");
  a_taps_bit_zero: assert property (rd && addr == 4'h2 |=> !rdata[0])
    else $error("tap bit 0 set");
  a_taps_read_back: assert property (wr && addr == 4'h2 ##2 rd && addr == 4'h2 |=>
    rdata == ($past(wdata, 3) & 16'hFFFE))
    else $error("taps read back wrong");
  a_event_one_cycle: assert property (crc_event |=> !crc_event)
    else $error("event longer than one cycle");
endmodule

bind pcrc_top pcrc_chk_sva u_sva (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .crc_event(crc_event));

// *** tb/testbench.sv ***
// Self-checking bench for the CRC generator
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        crc_event;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          ev_cnt = 0;
  int          n;

  pcrc_top u_dut (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .crc_event(crc_event));

  initial forever #2.5 mclk = ~mclk;

  always @(posedge mclk)
    if (crc_event === 1'b1)
      ev_cnt++;

  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
  endtask

  // Bounded wait; n counts cycles after the write
  task automatic wait_ev();
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (crc_event !== 1'b1 && n < 400);
    if (crc_event !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask

  function automatic logic [15:0] crc_of(logic [3:0] ln, logic [15:0] c0, logic [15:0] d);
    logic [16:0] c;
    logic        fb;
    c = {1'b0, c0};
    for (int i = 15; i >= 0; i--)
      if (i <= ln)
      begin
        fb = c[ln] ^ d[i];
        c = {c[15:0], 1'b0} ^ (fb ? 17'h1021 : 17'h0);
      end
    return c[15:0] & 16'((17'h1 << (ln + 1)) - 1);
  endfunction

  task automatic t_regs();
    rd_chk(4'h2, 16'h0000);
    wr_reg(4'h2, 16'hFFFF);
    rd_chk(4'h2, 16'hFFFE);
    wr_reg(4'h0, 16'hFFFF);
    rd_chk(4'h0, 16'h205F);
    wr_reg(4'h0, 16'h0000);
    rd_chk(4'hE, 16'h0000);
  endtask

  task automatic t_lens();
    logic [3:0] ln;
    wr_reg(4'h2, 16'h1020);
    for (int k = 0; k < 4; k++)
    begin
      ln = 4'(k * 5);
      wr_reg(4'h4, 16'h0000);
      wr_reg(4'h0, {12'h001, ln});
      wr_reg(4'h6, 16'hB7C5);
      wait_ev();
      chk(16'(n), 16'(ln) + 16'h0002);
      rd_chk(4'h4, crc_of(ln, 16'h0000, 16'hB7C5));
      rd_chk(4'h6, crc_of(ln, 16'h0000, 16'hB7C5));
      rd_chk(4'h0, {12'h005, ln});
    end
  endtask

  task automatic t_fifo();
    int e0;
    logic [15:0] c;
    wr_reg(4'h0, 16'h2007);
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'h6, 16'h0011);
    wr_reg(4'h8, 16'h0000);
    rd_chk(4'h0, 16'h2047);
    repeat (16) wr_reg(4'h6, 16'h0022);
    rd_chk(4'h0, 16'h3087);
    e0 = ev_cnt;
    wr_reg(4'h6, 16'h0033);
    rd_chk(4'h0, 16'h2047);
    chk(16'(ev_cnt), 16'(e0));
    wr_reg(4'h0, 16'h0008);
    repeat (8) wr_reg(4'h6, 16'h0144);
    rd_chk(4'h0, 16'h0888);
    wr_reg(4'h4, 16'h0000);
    wr_reg(4'h0, 16'h0018);
    wr_reg(4'h8, 16'h0001);
    repeat (40) @(posedge mclk);
    rd_chk(4'h0, 16'h0898);
    rd_chk(4'h8, 16'h0001);
    wr_reg(4'h8, 16'h0000);
    wait_ev();
    rd_chk(4'h0, 16'h0058);
    c = 16'h0000;
    repeat (8) c = crc_of(4'h8, c, 16'h0144);
    rd_chk(4'h4, c);
  endtask

  // Second reset after the FIFO has drained, with go set and taps loaded
  task automatic t_reset();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(4'h0, 16'h0040);
    rd_chk(4'h2, 16'h0000);
    rd_chk(4'h8, 16'h0000);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, 16'h0040);
    t_regs();
    t_lens();
    t_fifo();
    t_reset();
    wrap_up();
  end
endmodule
